// [rtl/uart_pkg.sv]
package uart_pkg;

	// clocking and bit-rate limits
	localparam int unsigned CLK_HZ    = 200_000_000;
	localparam int unsigned BAUD_DEF  = 9600;
	localparam int unsigned BAUD_LOW  = 183;
	localparam int unsigned BAUD_HIGH = 6_000_000;
	localparam logic [20:0] DIV_RST   = 21'(CLK_HZ / BAUD_DEF);
	localparam logic [20:0] DIV_MAX   = 21'(CLK_HZ / BAUD_LOW);
	// never faster than one eighth of the clock
	localparam logic [20:0] DIV_MIN   = 21'h8;

	// register byte offsets
	localparam logic [31:0] OFF_CTRL    = 32'h00;
	localparam logic [31:0] OFF_DIV     = 32'h04;
	localparam logic [31:0] OFF_TXDATA  = 32'h08;
	localparam logic [31:0] OFF_RXDATA  = 32'h0C;
	localparam logic [31:0] OFF_LINE    = 32'h10;
	localparam logic [31:0] OFF_INT_ST  = 32'h14;
	localparam logic [31:0] OFF_INT_EN  = 32'h18;
	localparam logic [31:0] OFF_INT_CLR = 32'h1C;

	typedef enum logic [3:0] {
		R_CTRL = 4'h0, R_DIV = 4'h1, R_TXDATA = 4'h2, R_RXDATA = 4'h3,
		R_LINE = 4'h4, R_INT_ST = 4'h5, R_INT_EN = 4'h6, R_INT_CLR = 4'h7,
		R_NONE = 4'hF
	} reg_sel_e;

	// control register fields
	localparam int CTRL_DATA8    = 0;
	localparam int CTRL_PAR_EN   = 1;
	localparam int CTRL_PAR_ODD  = 2;
	localparam int CTRL_TWO_STOP = 3;
	localparam int CTRL_FLOW     = 4;
	localparam int CTRL_RTS_ON   = 5;
	localparam int CTRL_DTR_ON   = 6;
	localparam int CTRL_WAKE_EN  = 7;
	localparam logic [7:0] CTRL_RST = 8'h11;

	// interrupt status fields
	localparam int IRQ_RX_READY = 0;
	localparam int IRQ_TX_EMPTY = 1;
	localparam int IRQ_FRAME    = 2;
	localparam int IRQ_PARITY   = 3;
	localparam int IRQ_OVERRUN  = 4;
	localparam int IRQ_RING     = 5;
	localparam int IRQ_CTS_CHG  = 6;
	localparam int IRQ_DCD_CHG  = 7;
	localparam logic [7:0] INT_EN_RST = 8'h00;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		TX_IDLE = 3'h0, TX_LEAD = 3'h1, TX_START = 3'h2, TX_DATA = 3'h3,
		TX_PAR = 3'h4, TX_STOP = 3'h5, TX_TRAIL = 3'h6
	} tx_state_e;

	typedef enum logic [2:0] {
		RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h2, RX_PAR = 3'h3,
		RX_STOP = 3'h4
	} rx_state_e;

	// parity bit over 7 or 8 data bits
	function automatic logic par_bit(input logic [7:0] d, input logic data8,
			input logic odd);
		par_bit = (^d[6:0]) ^ (data8 & d[7]) ^ odd;
	endfunction

endpackage

// [rtl/rx_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface rx_link_if;
	logic [20:0] div;
	logic        data8;
	logic        par_en;
	logic        par_odd;
	logic        two_stop;
	logic [7:0]  data;
	logic        done;
	logic        frame_err;
	logic        par_err;
	modport ctrl (output div, data8, par_en, par_odd, two_stop,
		input data, done, frame_err, par_err);
	modport rcv (input div, data8, par_en, par_odd, two_stop,
		output data, done, frame_err, par_err);
endinterface
`default_nettype wire

// [rtl/uart_rx.sv]
`timescale 1ns/1ps
`default_nettype none
module uart_rx (
	// clock and reset
	input  wire logic  ref_clk,
	input  wire logic  rst,
	// serial input
	input  wire logic  rxd,
	// configuration and received characters
	rx_link_if.rcv     lnk
);
	uart_pkg::rx_state_e state_q;
	logic [20:0] cnt_q;
	logic [2:0]  idx_q;
	logic        stop2_q;
	logic        prev_q;
	logic [7:0]  sh_q;
	logic        par_q;
	logic        done_q;
	logic        ferr_q;
	logic        perr_q;
	logic        tick;

	assign tick = (cnt_q == 21'h0);
	assign lnk.data = sh_q;
	assign lnk.done = done_q;
	assign lnk.frame_err = ferr_q;
	assign lnk.par_err = perr_q;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			prev_q <= 1'b1;
		end else begin
			prev_q <= rxd;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= uart_pkg::RX_IDLE;
			cnt_q   <= 21'h0;
			idx_q   <= 3'h0;
			stop2_q <= 1'b0;
			sh_q    <= 8'h00;
			par_q   <= 1'b0;
			done_q  <= 1'b0;
			ferr_q  <= 1'b0;
			perr_q  <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (state_q != uart_pkg::RX_IDLE && !tick)
				cnt_q <= cnt_q - 21'h1;
			else
				cnt_q <= lnk.div - 21'h1;
			case (state_q)
			uart_pkg::RX_IDLE: begin
				if (prev_q && !rxd) begin
					// first look lands mid start bit
					cnt_q   <= {1'b0, lnk.div[20:1]} - 21'h1;
					state_q <= uart_pkg::RX_START;
				end
			end
			uart_pkg::RX_START: begin
				if (tick) begin
					idx_q   <= 3'h0;
					sh_q    <= 8'h00;
					ferr_q  <= 1'b0;
					// a short glitch is not a start bit
					state_q <= rxd ? uart_pkg::RX_IDLE : uart_pkg::RX_DATA;
				end
			end
			uart_pkg::RX_DATA: begin
				if (tick) begin
					sh_q[idx_q] <= rxd;
					idx_q       <= idx_q + 3'h1;
					stop2_q     <= 1'b0;
					if (idx_q == {2'h3, lnk.data8})
						state_q <= lnk.par_en ? uart_pkg::RX_PAR : uart_pkg::RX_STOP;
				end
			end
			uart_pkg::RX_PAR: begin
				if (tick) begin
					par_q   <= rxd;
					state_q <= uart_pkg::RX_STOP;
				end
			end
			default: begin
				if (tick) begin
					if (!rxd)
						ferr_q <= 1'b1;
					if (lnk.two_stop && !stop2_q) begin
						stop2_q <= 1'b1;
					end else begin
						done_q  <= 1'b1;
						ferr_q  <= ferr_q | ~rxd;
						perr_q  <= lnk.par_en &&
							(uart_pkg::par_bit(sh_q, lnk.data8, lnk.par_odd) != par_q);
						state_q <= uart_pkg::RX_IDLE;
					end
				end
			end
			endcase
		end
	end
endmodule
`default_nettype wire

// [rtl/uart_port.sv]
// Overview of operation
// - bit rate programmable from 183 baud up to 25 Mbaud.
// - fastest bit period is eight clocks of the system clock.
// - frame is start, seven or eight data, optional parity, one/two stops.
// - data bits go out and come in least significant bit first.
// - bit rate resets to 9600 baud until software changes it.
// - flow control resets to request/clear-to-send handshake, changeable.
// - framing resets to eight bits, no parity, one stop; each settable.
// - transmit-active rises one bit period before the start bit.
// - transmit-active falls one bit period after the last frame ends.
// - transmit-active is an output usable as line driver direction.
// - active-low request-to-send out, active-low clear-to-send sampled.
// - active-low terminal-ready out, active-low carrier-detect sampled.
// - active-low ring input raises wake request when software enables it.
`timescale 1ns/1ps
`default_nettype none
module uart_port #(
	parameter logic [20:0] DEF_DIV = uart_pkg::DIV_RST
) (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// axi4-lite write address
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// serial line and modem control
	output logic             txd,
	input  wire logic        rxd,
	output logic             rts_n,
	input  wire logic        cts_n,
	output logic             dtr_n,
	input  wire logic        dcd_n,
	input  wire logic        ring_wake_n,
	output logic             tx_active,
	// system
	output logic             wake_req,
	output logic             irq
);
	// register bus state
	logic        aw_full_q;
	logic [31:0] aw_addr_q;
	logic        w_full_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        wr_go;
	uart_pkg::reg_sel_e wr_sel;
	uart_pkg::reg_sel_e rd_sel;
	logic        rd_go;
	logic [31:0] rd_val;
	// control and data registers
	logic [7:0]  ctrl_q;
	logic [20:0] div_q;
	logic [7:0]  int_en_q;
	logic [7:0]  int_stat_q;
	logic [7:0]  int_clr;
	logic [7:0]  events;
	logic [7:0]  tx_hold_q;
	logic        tx_full_q;
	logic [7:0]  rx_data_q;
	logic        rx_full_q;
	logic        rd_rx;
	logic        cts_prev_q;
	logic        dcd_prev_q;
	logic        ring_prev_q;
	// transmitter
	uart_pkg::tx_state_e tx_state_q;
	logic [20:0] tx_cnt_q;
	logic [7:0]  tx_sh_q;
	logic [2:0]  tx_idx_q;
	logic        tx_par_q;
	logic        tx_stop2_q;
	logic        tx_tick;
	logic        tx_go;
	logic        tx_load;

	rx_link_if lnk ();

	uart_rx u_rx (
		.ref_clk (ref_clk),
		.rst     (rst),
		.rxd     (rxd),
		.lnk     (lnk)
	);

	assign lnk.div      = div_q;
	assign lnk.data8    = ctrl_q[uart_pkg::CTRL_DATA8];
	assign lnk.par_en   = ctrl_q[uart_pkg::CTRL_PAR_EN];
	assign lnk.par_odd  = ctrl_q[uart_pkg::CTRL_PAR_ODD];
	assign lnk.two_stop = ctrl_q[uart_pkg::CTRL_TWO_STOP];

	function automatic uart_pkg::reg_sel_e decode(input logic [31:0] a);
		if (a == uart_pkg::OFF_CTRL)
			decode = uart_pkg::R_CTRL;
		else if (a == uart_pkg::OFF_DIV)
			decode = uart_pkg::R_DIV;
		else if (a == uart_pkg::OFF_TXDATA)
			decode = uart_pkg::R_TXDATA;
		else if (a == uart_pkg::OFF_RXDATA)
			decode = uart_pkg::R_RXDATA;
		else if (a == uart_pkg::OFF_LINE)
			decode = uart_pkg::R_LINE;
		else if (a == uart_pkg::OFF_INT_ST)
			decode = uart_pkg::R_INT_ST;
		else if (a == uart_pkg::OFF_INT_EN)
			decode = uart_pkg::R_INT_EN;
		else if (a == uart_pkg::OFF_INT_CLR)
			decode = uart_pkg::R_INT_CLR;
		else
			decode = uart_pkg::R_NONE;
	endfunction

	// byte-lane merge of a write into an existing value
	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [31:0] nw, input logic [3:0] strb);
		for (int i = 0; i < 4; i++)
			merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
	endfunction

	// out-of-range divisors are pinned to the limits
	function automatic logic [20:0] clamp_div(input logic [31:0] v);
		if (v < {11'h0, uart_pkg::DIV_MIN})
			clamp_div = uart_pkg::DIV_MIN;
		else if (v > {11'h0, uart_pkg::DIV_MAX})
			clamp_div = uart_pkg::DIV_MAX;
		else
			clamp_div = v[20:0];
	endfunction

	assign wr_go  = aw_full_q & w_full_q & ~s_axi_bvalid;
	assign wr_sel = decode(aw_addr_q);
	assign rd_go  = s_axi_arvalid & s_axi_arready;
	assign rd_sel = decode(s_axi_araddr);
	assign rd_rx  = rd_go && rd_sel == uart_pkg::R_RXDATA;
	assign int_clr = (wr_go && wr_sel == uart_pkg::R_INT_CLR && w_strb_q[0])
		? w_data_q[7:0] : 8'h00;

	always_comb begin
		rd_val = 32'h0;
		if (rd_sel == uart_pkg::R_CTRL)
			rd_val = {24'h0, ctrl_q};
		else if (rd_sel == uart_pkg::R_DIV)
			rd_val = {11'h0, div_q};
		else if (rd_sel == uart_pkg::R_RXDATA)
			rd_val = {24'h0, rx_data_q};
		else if (rd_sel == uart_pkg::R_LINE)
			rd_val = {26'h0, tx_full_q, rx_full_q,
				tx_state_q != uart_pkg::TX_IDLE, ~ring_wake_n, ~dcd_n, ~cts_n};
		else if (rd_sel == uart_pkg::R_INT_ST)
			rd_val = {24'h0, int_stat_q};
		else if (rd_sel == uart_pkg::R_INT_EN)
			rd_val = {24'h0, int_en_q};
	end

	// write channels are taken independently, then answered together
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			aw_full_q     <= 1'b0;
			aw_addr_q     <= 32'h0;
			s_axi_awready <= 1'b1;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_full_q     <= 1'b1;
			aw_addr_q     <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			aw_full_q     <= 1'b0;
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			w_full_q     <= 1'b0;
			w_data_q     <= 32'h0;
			w_strb_q     <= 4'h0;
			s_axi_wready <= 1'b1;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_full_q     <= 1'b1;
			w_data_q     <= s_axi_wdata;
			w_strb_q     <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			w_full_q     <= 1'b0;
			s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= uart_pkg::RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (wr_sel == uart_pkg::R_NONE) ?
				uart_pkg::RESP_SLVERR : uart_pkg::RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= uart_pkg::RESP_OKAY;
		end else if (rd_go) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_val;
			s_axi_rresp   <= (rd_sel == uart_pkg::R_NONE) ?
				uart_pkg::RESP_SLVERR : uart_pkg::RESP_OKAY;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// configuration registers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl_q   <= uart_pkg::CTRL_RST;
			div_q    <= DEF_DIV;
			int_en_q <= uart_pkg::INT_EN_RST;
		end else if (wr_go) begin
			if (wr_sel == uart_pkg::R_CTRL)
				ctrl_q <= 8'(merge({24'h0, ctrl_q}, w_data_q, w_strb_q));
			else if (wr_sel == uart_pkg::R_DIV)
				div_q <= clamp_div(merge({11'h0, div_q}, w_data_q, w_strb_q));
			else if (wr_sel == uart_pkg::R_INT_EN)
				int_en_q <= 8'(merge({24'h0, int_en_q}, w_data_q, w_strb_q));
		end
	end

	// transmit holding register; a write while full is dropped
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tx_hold_q <= 8'h00;
			tx_full_q <= 1'b0;
		end else if (tx_load) begin
			tx_full_q <= 1'b0;
		end else if (wr_go && wr_sel == uart_pkg::R_TXDATA && w_strb_q[0] &&
				!tx_full_q) begin
			tx_hold_q <= w_data_q[7:0];
			tx_full_q <= 1'b1;
		end
	end

	// receive data; a new character wins over a same-cycle read
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rx_data_q <= 8'h00;
			rx_full_q <= 1'b0;
		end else if (lnk.done) begin
			rx_data_q <= lnk.data;
			rx_full_q <= 1'b1;
		end else if (rd_rx) begin
			rx_full_q <= 1'b0;
		end
	end

	// modem lines; inputs are already in this clock domain
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cts_prev_q  <= 1'b1;
			dcd_prev_q  <= 1'b1;
			ring_prev_q <= 1'b1;
			rts_n       <= 1'b1;
			dtr_n       <= 1'b1;
			wake_req    <= 1'b0;
		end else begin
			cts_prev_q  <= cts_n;
			dcd_prev_q  <= dcd_n;
			ring_prev_q <= ring_wake_n;
			// under flow control, ready to receive while no byte is waiting
			rts_n <= ctrl_q[uart_pkg::CTRL_FLOW] ? rx_full_q
				: ~ctrl_q[uart_pkg::CTRL_RTS_ON];
			dtr_n    <= ~ctrl_q[uart_pkg::CTRL_DTR_ON];
			wake_req <= ctrl_q[uart_pkg::CTRL_WAKE_EN] & ~ring_wake_n;
		end
	end

	always_comb begin
		events = 8'h00;
		events[uart_pkg::IRQ_RX_READY] = lnk.done;
		events[uart_pkg::IRQ_TX_EMPTY] = tx_load;
		events[uart_pkg::IRQ_FRAME]    = lnk.done & lnk.frame_err;
		events[uart_pkg::IRQ_PARITY]   = lnk.done & lnk.par_err;
		events[uart_pkg::IRQ_OVERRUN]  = lnk.done & rx_full_q & ~rd_rx;
		events[uart_pkg::IRQ_RING]     = ring_prev_q & ~ring_wake_n;
		events[uart_pkg::IRQ_CTS_CHG]  = cts_prev_q ^ cts_n;
		events[uart_pkg::IRQ_DCD_CHG]  = dcd_prev_q ^ dcd_n;
	end

	// set beats clear so no event is lost
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			int_stat_q <= 8'h00;
			irq        <= 1'b0;
		end else begin
			int_stat_q <= (int_stat_q & ~int_clr) | events;
			irq        <= |(int_stat_q & int_en_q);
		end
	end

	// transmitter
	assign tx_tick = (tx_cnt_q == 21'h0);
	assign tx_go   = tx_full_q &
		~(ctrl_q[uart_pkg::CTRL_FLOW] & cts_n);
	assign tx_load = tx_tick && tx_go &&
		(tx_state_q == uart_pkg::TX_LEAD ||
		(tx_state_q == uart_pkg::TX_STOP &&
		(tx_stop2_q || !ctrl_q[uart_pkg::CTRL_TWO_STOP])));

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tx_state_q <= uart_pkg::TX_IDLE;
			tx_cnt_q   <= 21'h0;
			tx_sh_q    <= 8'h00;
			tx_idx_q   <= 3'h0;
			tx_par_q   <= 1'b0;
			tx_stop2_q <= 1'b0;
			txd        <= 1'b1;
			tx_active  <= 1'b0;
		end else begin
			if (tx_tick || tx_state_q == uart_pkg::TX_IDLE)
				tx_cnt_q <= div_q - 21'h1;
			else
				tx_cnt_q <= tx_cnt_q - 21'h1;
			if (tx_load) begin
				// back-to-back frames keep the driver enabled
				tx_state_q <= uart_pkg::TX_START;
				tx_sh_q    <= tx_hold_q;
				tx_par_q   <= uart_pkg::par_bit(tx_hold_q,
					ctrl_q[uart_pkg::CTRL_DATA8], ctrl_q[uart_pkg::CTRL_PAR_ODD]);
				txd        <= 1'b0;
			end else begin
				case (tx_state_q)
				uart_pkg::TX_IDLE: begin
					if (tx_go) begin
						tx_state_q <= uart_pkg::TX_LEAD;
						tx_active  <= 1'b1;
					end
				end
				uart_pkg::TX_LEAD: begin
					// clear-to-send dropped during the lead bit
					if (tx_tick) begin
						tx_state_q <= uart_pkg::TX_IDLE;
						tx_active  <= 1'b0;
					end
				end
				uart_pkg::TX_START: begin
					if (tx_tick) begin
						tx_state_q <= uart_pkg::TX_DATA;
						tx_idx_q   <= 3'h0;
						txd        <= tx_sh_q[0];
						tx_sh_q    <= {1'b0, tx_sh_q[7:1]};
					end
				end
				uart_pkg::TX_DATA: begin
					if (tx_tick) begin
						tx_idx_q   <= tx_idx_q + 3'h1;
						tx_stop2_q <= 1'b0;
						if (tx_idx_q == {2'h3, ctrl_q[uart_pkg::CTRL_DATA8]}) begin
							if (ctrl_q[uart_pkg::CTRL_PAR_EN]) begin
								tx_state_q <= uart_pkg::TX_PAR;
								txd        <= tx_par_q;
							end else begin
								tx_state_q <= uart_pkg::TX_STOP;
								txd        <= 1'b1;
							end
						end else begin
							txd     <= tx_sh_q[0];
							tx_sh_q <= {1'b0, tx_sh_q[7:1]};
						end
					end
				end
				uart_pkg::TX_PAR: begin
					if (tx_tick) begin
						tx_state_q <= uart_pkg::TX_STOP;
						txd        <= 1'b1;
					end
				end
				uart_pkg::TX_STOP: begin
					if (tx_tick) begin
						if (ctrl_q[uart_pkg::CTRL_TWO_STOP] && !tx_stop2_q)
							tx_stop2_q <= 1'b1;
						else
							tx_state_q <= uart_pkg::TX_TRAIL;
					end
				end
				default: begin
					if (tx_tick) begin
						tx_state_q <= uart_pkg::TX_IDLE;
						tx_active  <= 1'b0;
					end
				end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// [test/uart_port_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module uart_port_asserts (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// bus handshakes
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	// line side
	input wire logic txd,
	input wire logic tx_active,
	input wire logic ring_wake_n,
	input wire logic wake_req,
	input wire logic irq
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	// driver may be switched off only while the line rests at mark
	property p_idle; !tx_active |-> txd; endproperty
	a_idle: assert property (p_idle)
		else $error("txd low with transmitter off");
	property p_lead; $rose(tx_active) |-> txd [*8]; endproperty
	a_lead: assert property (p_lead)
		else $error("start bit too soon after enable");
	property p_start; $fell(txd) |-> $past(tx_active, 8); endproperty
	a_start: assert property (p_start)
		else $error("txd fell without enable lead");
	property p_trail;
		$fell(tx_active) |-> $past(txd, 1) && $past(txd, 8);
	endproperty
	a_trail: assert property (p_trail)
		else $error("enable dropped without trail bit");
	// divisor floor of eight clocks bounds every bit
	property p_bit; tx_active && $changed(txd) |=> $stable(txd) [*7];
	endproperty
	a_bit: assert property (p_bit)
		else $error("bit shorter than eight clocks");
	property p_wake; wake_req |-> !$past(ring_wake_n); endproperty
	a_wake: assert property (p_wake)
		else $error("wake without ring");
	property p_b_busy;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_b_busy: assert property (p_b_busy)
		else $error("write taken while response pending");
	property p_r_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_r_busy: assert property (p_r_busy)
		else $error("read taken while data pending");

	c_frame: cover property ($rose(tx_active));
	c_wake: cover property ($rose(wake_req));
	c_irq: cover property ($rose(irq));
endmodule

bind uart_port uart_port_asserts chk_u (.ref_clk, .rst, .s_axi_awready,
	.s_axi_wready, .s_axi_bvalid, .s_axi_arready, .s_axi_rvalid, .txd,
	.tx_active, .ring_wake_n, .wake_req, .irq);
`default_nettype wire

// [test/serial_peer.sv]
`timescale 1ns/1ps
`default_nettype none
module serial_peer #(
	parameter int DIV = 8
) (
	input wire logic ref_clk,
	input wire logic txd,
	output logic     rxd,
	output logic     cts_n
);
	int         nb = 8;
	logic       pe = 0;
	logic       po = 0;
	logic       two = 0;
	logic [7:0] got [$];
	int         bad = 0;
	logic [7:0] sh;

	initial begin
		rxd = 1;
		cts_n = 0;
	end

	// mid-bit sampling, so edge placement slop is tolerated
	always begin
		@(negedge txd);
		repeat (DIV / 2) @(posedge ref_clk);
		if (txd !== 0) bad++;
		sh = 0;
		for (int i = 0; i < nb; i++) begin
			repeat (DIV) @(posedge ref_clk);
			sh[i] = txd;
		end
		if (pe) begin
			repeat (DIV) @(posedge ref_clk);
			if (txd !== (^sh ^ po)) bad++;
		end
		repeat (DIV) @(posedge ref_clk);
		if (txd !== 1) bad++;
		got.push_back(sh);
	end

	task automatic bitx(input logic v);
		rxd <= v;
		repeat (DIV) @(posedge ref_clk);
	endtask

	task automatic send(input logic [7:0] v, input logic stop_ok);
		logic [7:0] w;
		w = (nb == 8) ? v : {1'b0, v[6:0]};
		@(posedge ref_clk);
		bitx(0);
		for (int i = 0; i < nb; i++) bitx(w[i]);
		if (pe) bitx(^w ^ po);
		bitx(stop_ok);
		if (two) bitx(1);
		rxd <= 1;
	endtask
endmodule
`default_nettype wire

// [test/tb_async_serial_port_with_flow_control.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_async_serial_port_with_flow_control;
	logic        ref_clk = 0;
	logic        rst = 1;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic        txd, rxd, rts_n, cts_n, dtr_n, dcd_n, ring_wake_n;
	logic        tx_active, wake_req, irq;
	int          n_mismatch = 0;
	int          num_checks = 0;
	int          cyc = 0;
	logic [31:0] d;
	logic [1:0]  r;
	logic [7:0]  tv, mk;
	logic [7:0]  modes [4] = '{8'h11, 8'h13, 8'h1E, 8'h18};

	always #2.5 ref_clk = ~ref_clk;

	uart_port dut_u (.ref_clk, .rst, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .txd,
		.rxd, .rts_n, .cts_n, .dtr_n, .dcd_n, .ring_wake_n, .tx_active,
		.wake_req, .irq);
	serial_peer #(.DIV(8)) peer_u (.ref_clk, .txd, .rxd, .cts_n);

	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			$display("unexpected t=%0t run too long", $time);
			test_done;
		end
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("unexpected t=%0t seen %h want %h", $time, s, e);
		end
	endtask

	// ready sampled mid-cycle, where no flop is moving
	task automatic wr(input logic [31:0] a, input logic [31:0] v);
		logic ka, kw, kb;
		ka = 0;
		kw = 0;
		kb = 0;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!(ka && kw)) begin
			@(negedge ref_clk);
			ka |= s_axi_awready & s_axi_awvalid;
			kw |= s_axi_wready & s_axi_wvalid;
			@(posedge ref_clk);
			if (ka) s_axi_awvalid <= 0;
			if (kw) s_axi_wvalid <= 0;
		end
		while (!kb) begin
			@(negedge ref_clk);
			kb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge ref_clk);
		end
		s_axi_bready <= 0;
	endtask

	task automatic rd(input logic [31:0] a);
		logic k;
		k = 0;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		while (!k) begin
			@(negedge ref_clk);
			k = s_axi_arready;
			@(posedge ref_clk);
		end
		s_axi_arvalid <= 0;
		k = 0;
		while (!k) begin
			@(negedge ref_clk);
			k = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge ref_clk);
		end
		s_axi_rready <= 0;
	endtask

	task automatic rdc(input logic [31:0] a, input logic [31:0] e);
		rd(a);
		chk(d, e);
	endtask

	task automatic cfg(input logic [7:0] c);
		peer_u.nb = c[0] ? 8 : 7;
		peer_u.pe = c[1];
		peer_u.po = c[2];
		peer_u.two = c[3];
	endtask

	task automatic wt;
		for (int i = 0; i < 400; i++) begin
			if (peer_u.got.size() > 0 && tx_active === 0) break;
			@(posedge ref_clk);
		end
	endtask

	initial begin
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		dcd_n = 1;
		ring_wake_n = 1;
		repeat (20) @(posedge ref_clk);
		rst <= 0;
		rdc(uart_pkg::OFF_CTRL, 32'h11);
		rdc(uart_pkg::OFF_DIV, 32'(uart_pkg::DIV_RST));
		rdc(uart_pkg::OFF_INT_EN, 32'h0);
		chk(32'(r), 32'(uart_pkg::RESP_OKAY));
		rdc(32'h40, 32'h0);
		chk(32'(r), 32'(uart_pkg::RESP_SLVERR));
		wr(32'h40, 32'h0);
		chk(32'(r), 32'(uart_pkg::RESP_SLVERR));
		$display("test reset done");
		wr(uart_pkg::OFF_DIV, 32'h4);
		chk(32'(r), 32'(uart_pkg::RESP_OKAY));
		rdc(uart_pkg::OFF_DIV, 32'h8);
		wr(uart_pkg::OFF_DIV, 32'h001FFFFF);
		rdc(uart_pkg::OFF_DIV, 32'h0010AD20);
		wr(uart_pkg::OFF_DIV, 32'h8);
		$display("test rate done");
		foreach (modes[m]) begin
			wr(uart_pkg::OFF_CTRL, 32'(modes[m]));
			cfg(modes[m]);
			tv = 8'hB3 ^ 8'(m);
			mk = modes[m][0] ? 8'hFF : 8'h7F;
			wr(uart_pkg::OFF_TXDATA, 32'(tv));
			wt;
			chk(32'(peer_u.got.pop_front()), 32'(tv & mk));
			chk(32'(peer_u.bad), 32'h0);
			peer_u.send(~tv, 1);
			repeat (4) @(posedge ref_clk);
			rdc(uart_pkg::OFF_RXDATA, 32'(~tv & mk));
		end
		$display("test framing done");
		wr(uart_pkg::OFF_CTRL, 32'h11);
		cfg(8'h11);
		peer_u.cts_n <= 1;
		wr(uart_pkg::OFF_TXDATA, 32'h3C);
		repeat (100) @(posedge ref_clk);
		chk(32'(tx_active), 32'h0);
		chk(32'(peer_u.got.size()), 32'h0);
		peer_u.cts_n <= 0;
		wt;
		chk(32'(peer_u.got.pop_front()), 32'h3C);
		$display("test flow done");
		wr(uart_pkg::OFF_INT_CLR, 32'hFF);
		wr(uart_pkg::OFF_INT_EN, 32'h04);
		peer_u.send(8'h5A, 0);
		repeat (4) @(posedge ref_clk);
		chk(32'(irq), 32'h1);
		rd(uart_pkg::OFF_INT_ST);
		chk(d, 32'h05);
		wr(uart_pkg::OFF_INT_CLR, 32'h04);
		repeat (3) @(posedge ref_clk);
		chk(32'(irq), 32'h0);
		$display("test error done");
		wr(uart_pkg::OFF_CTRL, 32'hE0);
		dcd_n <= 0;
		ring_wake_n <= 0;
		repeat (4) @(posedge ref_clk);
		chk(32'(rts_n), 32'h0);
		chk(32'(dtr_n), 32'h0);
		chk(32'(wake_req), 32'h1);
		rd(uart_pkg::OFF_LINE);
		chk(d, 32'h17);
		wr(uart_pkg::OFF_CTRL, 32'h00);
		repeat (3) @(posedge ref_clk);
		chk(32'({rts_n, dtr_n, wake_req}), 32'h6);
		$display("test modem done");
		test_done;
	end
endmodule
`default_nettype wire
